// [core/cmbf_core.v]
// Message buffer format engine: software access, frame fetch, frame store
`timescale 1ns/10ps
`include "cmbf_defs.vh"
module cmbf_core (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Software buffer access
    input wire cpu_we,
    input wire cpu_re,
    input wire [`CMBF_BUF_W-1:0] cpu_buf,
    input wire [`CMBF_WORD_W-1:0] cpu_word,
    input wire [15:0] cpu_wdata,
    output reg [15:0] cpu_rdata_r,
    output reg cpu_rvalid_r,
    // Engine status
    output reg eng_ready_r,
    // Transmit fetch
    input wire tx_req,
    input wire [`CMBF_BUF_W-1:0] tx_buf,
    output reg tx_valid_r,
    output reg [10:0] tx_std_ident_r,
    output reg [17:0] tx_ext_ident_r,
    output reg tx_srr_r,
    output reg tx_ide_r,
    output reg tx_rtr_r,
    output reg tx_reserved_zero_hi_r,
    output reg tx_reserved_zero_lo_r,
    output reg [3:0] tx_dlc_r,
    output reg [63:0] tx_data_r,
    // Receive store
    input wire rx_req,
    input wire [`CMBF_BUF_W-1:0] rx_buf,
    input wire [10:0] rx_std_ident,
    input wire [17:0] rx_ext_ident,
    input wire rx_srr,
    input wire rx_ide,
    input wire rx_rtr,
    input wire [3:0] rx_dlc,
    input wire [63:0] rx_data,
    input wire [4:0] rx_accept_filter_index,
    output reg rx_done_r
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_TXRD = 4'h2;
    localparam [3:0] ST_TXWT = 4'h4;
    localparam [3:0] ST_RXWR = 4'h8;

    // Buffer base plus word offset
    function [`CMBF_ADDR_W-1:0] buf_addr;
        input [`CMBF_BUF_W-1:0] b;
        input [`CMBF_WORD_W-1:0] w;
        begin
            buf_addr = {b, w};
        end
    endfunction

    // Implemented bits of each word
    function [15:0] word_mask;
        input [`CMBF_WORD_W-1:0] w;
        begin
            case (w)
                `CMBF_W_STD: word_mask = `CMBF_MASK_W0;
                `CMBF_W_EXTH: word_mask = `CMBF_MASK_W1;
                `CMBF_W_EXTL: word_mask = `CMBF_MASK_W2;
                `CMBF_W_HIT: word_mask = `CMBF_MASK_W7;
                default: word_mask = `CMBF_MASK_DATA;
            endcase
        end
    endfunction

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [2:0] cnt_r;
    reg [`CMBF_BUF_W-1:0] ebuf_r;
    reg rd_vld_r;
    reg [2:0] rd_word_r;
    reg cpu_rd1_r;
    reg [2:0] cpu_word1_r;
    // Latched receive frame
    reg [10:0] l_std_r;
    reg [17:0] l_ext_r;
    reg l_srr_r;
    reg l_ide_r;
    reg l_rtr_r;
    reg [3:0] l_dlc_r;
    reg [63:0] l_data_r;
    reg [4:0] l_hit_r;

    wire [15:0] a_q;
    wire [15:0] b_q;
    wire [`CMBF_ADDR_W-1:0] eng_addr;
    wire eng_we;
    reg [15:0] eng_wdata;
    wire rx_take;

    assign eng_addr = buf_addr(ebuf_r, cnt_r);
    assign eng_we = (state_r == ST_RXWR);

    // Store request accepted this cycle
    assign rx_take = (state_r == ST_IDLE) && !tx_req && rx_req;

    // Software writes go straight into buffer storage
    cmbf_ram u_ram (
        .clock(clock),
        .a_we(cpu_we),
        .a_addr(buf_addr(cpu_buf, cpu_word)),
        .a_wdata(cpu_wdata),
        .a_q(a_q),
        .b_we(eng_we),
        .b_addr(eng_addr),
        .b_wdata(eng_wdata),
        .b_q(b_q)
    );

    // Receive word packing; unused bits forced to zero
    always @* begin
        eng_wdata = 16'h0000;
        case (cnt_r)
            `CMBF_W_STD: begin
                eng_wdata[`CMBF_STD_HI:`CMBF_STD_LO] = l_std_r;
                eng_wdata[`CMBF_SRR_BIT] = l_srr_r;
                eng_wdata[`CMBF_IDE_BIT] = l_ide_r;
            end
            `CMBF_W_EXTH: begin
                eng_wdata[`CMBF_EXTH_HI:`CMBF_EXTH_LO] = l_ext_r[17:6];
            end
            `CMBF_W_EXTL: begin
                eng_wdata[`CMBF_EXTL_HI:`CMBF_EXTL_LO] = l_ext_r[5:0];
                eng_wdata[`CMBF_RTR_BIT] = l_rtr_r;
                eng_wdata[`CMBF_DLC_HI:`CMBF_DLC_LO] = l_dlc_r;
            end
            `CMBF_W_D01: eng_wdata = l_data_r[15:0];
            `CMBF_W_D23: eng_wdata = l_data_r[31:16];
            `CMBF_W_D45: eng_wdata = l_data_r[47:32];
            `CMBF_W_D67: eng_wdata = l_data_r[63:48];
            default: begin
                eng_wdata[`CMBF_HIT_HI:`CMBF_HIT_LO] = l_hit_r;
            end
        endcase
    end

    // Engine sequencing
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (tx_req) begin
                    state_nxt = ST_TXRD;
                end else if (rx_req) begin
                    state_nxt = ST_RXWR;
                end
            end
            ST_TXRD: begin
                // Word 7 is never fetched for transmit
                if (cnt_r == `CMBF_W_D67) begin
                    state_nxt = ST_TXWT;
                end
            end
            ST_TXWT: begin
                if (rd_vld_r && rd_word_r == `CMBF_W_D67) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_RXWR: begin
                if (cnt_r == `CMBF_W_HIT) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Control state; buffer contents untouched by reset
    always @(posedge clock) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            ebuf_r <= {`CMBF_BUF_W{1'b0}};
            rd_vld_r <= 1'b0;
            rd_word_r <= 3'h0;
            eng_ready_r <= 1'b1;
            rx_done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            eng_ready_r <= (state_nxt == ST_IDLE);
            rd_vld_r <= (state_r == ST_TXRD);
            rd_word_r <= cnt_r;
            rx_done_r <= (state_r == ST_RXWR) && (cnt_r == `CMBF_W_HIT);
            if (state_r == ST_IDLE) begin
                cnt_r <= 3'h0;
                if (tx_req) begin
                    ebuf_r <= tx_buf;
                end else if (rx_req) begin
                    ebuf_r <= rx_buf;
                end
            end else if (state_r == ST_TXRD || state_r == ST_RXWR) begin
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end

    // Receive frame capture
    always @(posedge clock) begin
        if (rst) begin
            l_std_r <= 11'h000;
            l_ext_r <= 18'h00000;
            l_srr_r <= 1'b0;
            l_ide_r <= 1'b0;
            l_rtr_r <= 1'b0;
            l_dlc_r <= 4'h0;
            l_data_r <= 64'h0000000000000000;
            l_hit_r <= 5'h00;
        end else if (rx_take) begin
            l_std_r <= rx_std_ident;
            l_ext_r <= rx_ext_ident;
            l_srr_r <= rx_srr;
            l_ide_r <= rx_ide;
            l_rtr_r <= rx_rtr;
            l_dlc_r <= rx_dlc;
            l_data_r <= rx_data;
            l_hit_r <= rx_accept_filter_index;
        end
    end

    // Transmit field unpacking
    always @(posedge clock) begin
        if (rst) begin
            tx_valid_r <= 1'b0;
            tx_std_ident_r <= 11'h000;
            tx_ext_ident_r <= 18'h00000;
            tx_srr_r <= 1'b0;
            tx_ide_r <= 1'b0;
            tx_rtr_r <= 1'b0;
            tx_reserved_zero_hi_r <= 1'b0;
            tx_reserved_zero_lo_r <= 1'b0;
            tx_dlc_r <= 4'h0;
            tx_data_r <= 64'h0000000000000000;
        end else begin
            tx_valid_r <= rd_vld_r && (rd_word_r == `CMBF_W_D67);
            if (rd_vld_r) begin
                case (rd_word_r)
                    `CMBF_W_STD: begin
                        tx_std_ident_r <= b_q[`CMBF_STD_HI:`CMBF_STD_LO];
                        tx_srr_r <= b_q[`CMBF_SRR_BIT];
                        tx_ide_r <= b_q[`CMBF_IDE_BIT];
                    end
                    `CMBF_W_EXTH: begin
                        tx_ext_ident_r[17:6] <= b_q[`CMBF_EXTH_HI:`CMBF_EXTH_LO];
                    end
                    `CMBF_W_EXTL: begin
                        tx_ext_ident_r[5:0] <= b_q[`CMBF_EXTL_HI:`CMBF_EXTL_LO];
                        tx_rtr_r <= b_q[`CMBF_RTR_BIT];
                        // Reserved bits passed on as software wrote them
                        tx_reserved_zero_hi_r <= b_q[`CMBF_RZH_BIT];
                        tx_reserved_zero_lo_r <= b_q[`CMBF_RZL_BIT];
                        tx_dlc_r <= b_q[`CMBF_DLC_HI:`CMBF_DLC_LO];
                    end
                    `CMBF_W_D01: tx_data_r[15:0] <= b_q;
                    `CMBF_W_D23: tx_data_r[31:16] <= b_q;
                    `CMBF_W_D45: tx_data_r[47:32] <= b_q;
                    `CMBF_W_D67: tx_data_r[63:48] <= b_q;
                    default: tx_data_r <= tx_data_r;
                endcase
            end
        end
    end

    // Software read path with unused bits masked
    always @(posedge clock) begin
        if (rst) begin
            cpu_rd1_r <= 1'b0;
            cpu_word1_r <= 3'h0;
            cpu_rvalid_r <= 1'b0;
            cpu_rdata_r <= 16'h0000;
        end else begin
            cpu_rd1_r <= cpu_re;
            cpu_word1_r <= cpu_word;
            cpu_rvalid_r <= cpu_rd1_r;
            if (cpu_rd1_r) begin
                cpu_rdata_r <= a_q & word_mask(cpu_word1_r);
            end
        end
    end
endmodule

// [core/cmbf_defs.vh]
// Message buffer layout constants
`ifndef CMBF_DEFS_VH
`define CMBF_DEFS_VH
`define CMBF_NBUF 32
`define CMBF_BUF_W 5
`define CMBF_WORDS 8
`define CMBF_WORD_W 3
`define CMBF_ADDR_W 8
`define CMBF_DATA_W 16
// Word indices
`define CMBF_W_STD 3'h0
`define CMBF_W_EXTH 3'h1
`define CMBF_W_EXTL 3'h2
`define CMBF_W_D01 3'h3
`define CMBF_W_D23 3'h4
`define CMBF_W_D45 3'h5
`define CMBF_W_D67 3'h6
`define CMBF_W_HIT 3'h7
// Word 0 fields
`define CMBF_STD_HI 12
`define CMBF_STD_LO 2
`define CMBF_SRR_BIT 1
`define CMBF_IDE_BIT 0
// Word 1 field
`define CMBF_EXTH_HI 11
`define CMBF_EXTH_LO 0
// Word 2 fields
`define CMBF_EXTL_HI 15
`define CMBF_EXTL_LO 10
`define CMBF_RTR_BIT 9
`define CMBF_RZH_BIT 8
`define CMBF_RZL_BIT 4
`define CMBF_DLC_HI 3
`define CMBF_DLC_LO 0
// Word 7 field
`define CMBF_HIT_HI 12
`define CMBF_HIT_LO 8
// Implemented-bit masks
`define CMBF_MASK_W0 16'h1FFF
`define CMBF_MASK_W1 16'h0FFF
`define CMBF_MASK_W2 16'hFF1F
`define CMBF_MASK_DATA 16'hFFFF
`define CMBF_MASK_W7 16'h1F00
// Read latency in cycles
`define CMBF_RD_LAT 2
`endif

// [core/cmbf_ram.v]
// Message buffer storage with a software port and an engine port
`timescale 1ns/10ps
`include "cmbf_defs.vh"
module cmbf_ram (
    // Clock
    input wire clock,
    // Software port
    input wire a_we,
    input wire [`CMBF_ADDR_W-1:0] a_addr,
    input wire [`CMBF_DATA_W-1:0] a_wdata,
    output reg [`CMBF_DATA_W-1:0] a_q,
    // Engine port
    input wire b_we,
    input wire [`CMBF_ADDR_W-1:0] b_addr,
    input wire [`CMBF_DATA_W-1:0] b_wdata,
    output reg [`CMBF_DATA_W-1:0] b_q
);
    reg [`CMBF_DATA_W-1:0] mem [0:`CMBF_NBUF*`CMBF_WORDS-1];

    // No reset of contents; engine write wins a same-address clash
    always @(posedge clock) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_q <= mem[a_addr];
        b_q <= mem[b_addr];
    end
endmodule

// [tb/cmbf_checker.sv]
// Port checker for the message buffer engine
`timescale 1ns/10ps
module cmbf_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Software port
    input wire logic cpu_re,
    input wire logic [2:0] cpu_word,
    input wire logic [15:0] cpu_rdata_r,
    input wire logic cpu_rvalid_r,
    // Engine
    input wire logic eng_ready_r,
    input wire logic tx_req,
    input wire logic tx_valid_r,
    input wire logic rx_req,
    input wire logic rx_done_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [2:0] w1_r;
    logic [2:0] w2_r;
    logic [15:0] unused;
    // Word index of the read now answering
    always @(posedge clock) begin
        w1_r <= cpu_word;
        w2_r <= w1_r;
    end
    always_comb begin
        case (w2_r)
            3'h0: unused = 16'hE000;
            3'h1: unused = 16'hF000;
            3'h2: unused = 16'h00E0;
            3'h7: unused = 16'hE0FF;
            default: unused = 16'h0000;
        endcase
    end
    a_read_latency: assert property (cpu_re |-> ##2 cpu_rvalid_r)
        else $error("read answer late");
    a_rvalid_cause: assert property (cpu_rvalid_r |-> $past(cpu_re, 2))
        else $error("read answer without request");
    a_unused_zero: assert property (cpu_rvalid_r |-> ~|(cpu_rdata_r & unused))
        else $error("unused bits not zero");
    a_tx_latency: assert property (tx_req && eng_ready_r |-> ##9 tx_valid_r)
        else $error("fetch answer late");
    a_tx_busy: assert property (tx_req && eng_ready_r |=>
        !eng_ready_r [*8] ##1 eng_ready_r)
        else $error("fetch busy span wrong");
    a_rx_latency: assert property (rx_req && !tx_req && eng_ready_r |-> ##9 rx_done_r)
        else $error("store answer late");
    a_rx_busy: assert property (rx_req && !tx_req && eng_ready_r |=>
        !eng_ready_r [*8] ##1 eng_ready_r)
        else $error("store busy span wrong");
    a_done_cause: assert property (rx_done_r |->
        $past(rx_req, 9) && !$past(tx_req, 9))
        else $error("store done without store");
endmodule
bind cmbf_core cmbf_checker cmbf_checker_i (.clock, .rst, .cpu_re, .cpu_word, .cpu_rdata_r,
    .cpu_rvalid_r, .eng_ready_r, .tx_req, .tx_valid_r, .rx_req, .rx_done_r);

// [tb/cmbf_frame_src.sv]
// Received frame source on the store side of the engine
`timescale 1ns/10ps
module cmbf_frame_src (
    // Clock
    input wire logic clock,
    // Store handshake
    input wire logic rx_done_r,
    output logic rx_req,
    // Frame fields
    output logic [4:0] rx_buf,
    output logic [10:0] rx_std_ident,
    output logic [17:0] rx_ext_ident,
    output logic rx_srr,
    output logic rx_ide,
    output logic rx_rtr,
    output logic [3:0] rx_dlc,
    output logic [63:0] rx_data,
    output logic [4:0] rx_accept_filter_index
);
    logic [109:0] f;
    assign {rx_buf, rx_std_ident, rx_ext_ident, rx_srr, rx_ide, rx_rtr, rx_dlc, rx_data,
        rx_accept_filter_index} = f;
    initial {rx_req, f} = {1'h0, 110'h0};
    // One frame; fields scrambled once released
    task automatic send(input logic [109:0] v, output logic ok);
        @(negedge clock);
        {rx_req, f} = {1'h1, v};
        @(negedge clock);
        {rx_req, f} = {1'h0, ~v};
        repeat (12) if (rx_done_r !== 1'h1) @(negedge clock);
        ok = (rx_done_r === 1'h1);
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the message buffer engine
`timescale 1ns/10ps
module testbench;
    logic clock, rst, cpu_we, cpu_re, tx_req;
    logic [4:0] cpu_buf, tx_buf;
    logic [2:0] cpu_word;
    logic [15:0] cpu_wdata;
    wire [15:0] rdata;
    wire rvalid, ready, tx_valid, srr, ide, rtr, rz_hi, rz_lo, done;
    wire rx_req, rx_srr, rx_ide, rx_rtr;
    wire [10:0] std, rx_std;
    wire [17:0] ext, rx_ext;
    wire [3:0] dlc, rx_dlc;
    wire [63:0] data, rx_data;
    wire [4:0] rx_buf, rx_filt;
    int mismatches = 0;
    int n_compared = 0;
    logic [15:0] msk [8] = '{16'h1FFF, 16'h0FFF, 16'hFF1F, 16'hFFFF, 16'hFFFF, 16'hFFFF,
        16'hFFFF, 16'h1F00};
    cmbf_core cmbf_core_i (.clock(clock), .rst(rst), .cpu_we(cpu_we), .cpu_re(cpu_re),
        .cpu_buf(cpu_buf), .cpu_word(cpu_word), .cpu_wdata(cpu_wdata), .cpu_rdata_r(rdata),
        .cpu_rvalid_r(rvalid), .eng_ready_r(ready), .tx_req(tx_req), .tx_buf(tx_buf),
        .tx_valid_r(tx_valid), .tx_std_ident_r(std), .tx_ext_ident_r(ext), .tx_srr_r(srr),
        .tx_ide_r(ide), .tx_rtr_r(rtr), .tx_reserved_zero_hi_r(rz_hi),
        .tx_reserved_zero_lo_r(rz_lo), .tx_dlc_r(dlc), .tx_data_r(data), .rx_req(rx_req),
        .rx_buf(rx_buf), .rx_std_ident(rx_std), .rx_ext_ident(rx_ext), .rx_srr(rx_srr),
        .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data),
        .rx_accept_filter_index(rx_filt), .rx_done_r(done));
    cmbf_frame_src cmbf_frame_src_i (.clock(clock), .rx_done_r(done), .rx_req(rx_req),
        .rx_buf(rx_buf), .rx_std_ident(rx_std), .rx_ext_ident(rx_ext), .rx_srr(rx_srr),
        .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data),
        .rx_accept_filter_index(rx_filt));
    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Buffer word image of a frame {buf,std,ext,srr,ide,rtr,dlc,data,filter}
    function automatic logic [15:0] wd(input int k, input logic [109:0] f);
        case (k)
            0: return {3'h0, f[104:94], f[75:74]};
            1: return {4'h0, f[93:82]};
            2: return {f[81:76], f[73], 1'h0, 3'h0, 1'h0, f[72:69]};
            7: return {3'h0, f[4:0], 8'h00};
            default: return f[5 + 16 * (k - 3) +: 16];
        endcase
    endfunction
    task automatic wr(input logic [4:0] b, input logic [2:0] w, input logic [15:0] d);
        @(negedge clock);
        {cpu_we, cpu_buf, cpu_word, cpu_wdata} = {1'h1, b, w, d};
        @(negedge clock);
        cpu_we = 1'h0;
    endtask
    task automatic rd(input logic [4:0] b, input logic [2:0] w, input logic [15:0] exp);
        @(negedge clock);
        {cpu_re, cpu_buf, cpu_word} = {1'h1, b, w};
        @(negedge clock);
        cpu_re = 1'h0;
        @(negedge clock);
        chk(rvalid, 1'h1);
        chk(rdata, exp);
    endtask
    task automatic fetch(input logic [4:0] b);
        @(negedge clock);
        {tx_req, tx_buf} = {1'h1, b};
        @(negedge clock);
        tx_req = 1'h0;
        repeat (12) if (tx_valid !== 1'h1) @(negedge clock);
        chk(tx_valid, 1'h1);
    endtask
    task automatic chk_tx(input logic [109:0] f);
        chk(std, f[104:94]);
        chk(ext, f[93:76]);
        chk({srr, ide, rtr}, f[75:73]);
        chk(dlc, f[72:69]);
        chk(data, f[68:5]);
        chk({rz_hi, rz_lo}, 2'h0);
    endtask
    // All ones written, unused bits read back as zero
    task automatic t_mask();
        for (int k = 0; k < 8; k++) wr(5'h03, 3'(k), 16'hFFFF);
        for (int k = 0; k < 8; k++) rd(5'h03, 3'(k), msk[k]);
    endtask
    // Software builds a frame, engine fetches it
    task automatic t_tx(input logic [109:0] f);
        for (int k = 0; k < 7; k++) wr(f[109:105], 3'(k), wd(k, f));
        fetch(f[109:105]);
        chk_tx(f);
    endtask
    // Stored frame read back, then fetched without touching the hit field
    task automatic t_rx(input logic [109:0] f);
        logic ok;
        cmbf_frame_src_i.send(f, ok);
        chk(ok, 1'h1);
        for (int k = 0; k < 8; k++) rd(f[109:105], 3'(k), wd(k, f));
        fetch(f[109:105]);
        chk_tx(f);
        rd(f[109:105], 3'h7, wd(7, f));
    endtask
    // Fetch and store in one cycle: fetch wins, store dropped
    task automatic t_clash(input logic [109:0] f, input logic [109:0] g);
        logic ok;
        fork
            fetch(f[109:105]);
            cmbf_frame_src_i.send(g, ok);
        join
        chk(ok, 1'h0);
        chk_tx(f);
    endtask
    // Mid-run reset leaves buffer contents alone
    task automatic t_reset(input logic [109:0] f);
        @(negedge clock);
        rst = 1'h1;
        repeat (2) @(negedge clock);
        rst = 1'h0;
        chk({ready, tx_valid, rvalid, done}, 4'h8);
        chk(std, 11'h000);
        for (int k = 0; k < 8; k++) rd(f[109:105], 3'(k), wd(k, f));
    endtask
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    initial begin
        {rst, cpu_we, cpu_re, tx_req, cpu_buf, cpu_word, cpu_wdata, tx_buf} = 33'h100000000;
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst = 1'h0;
        t_mask();
        t_tx({5'h00, 11'h7FF, 18'h00000, 3'h7, 4'h8, 64'h8877665544332211, 5'h00});
        t_tx({5'h1F, 11'h000, 18'h3FFFF, 3'h0, 4'h0, 64'h0123456789ABCDEF, 5'h00});
        t_rx({5'h09, 11'h2A5, 18'h1ACE3, 3'h5, 4'hF, 64'hFEDCBA9876543210, 5'h15});
        t_clash({5'h00, 11'h7FF, 18'h00000, 3'h7, 4'h8, 64'h8877665544332211, 5'h00},
            {5'h09, 11'h155, 18'h2531C, 3'h2, 4'h3, 64'h0F1E2D3C4B5A6978, 5'h0A});
        t_reset({5'h09, 11'h2A5, 18'h1ACE3, 3'h5, 4'hF, 64'hFEDCBA9876543210, 5'h15});
        give_verdict();
    end
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule
